// ---- core/msu_host.sv ----
// Processor-side controller: APB orders become unit register accesses.
`include "msu_map.svh"

module msu_host (
	// Clock and reset.
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Unit register port.
	msu_if.host              port
);
	import msu_pkg::*;

	//////////////////////////////////////////////////////////////////////
	logic               wr, next_wr;
	logic               rd, next_rd;
	msu_addr_t          addr, next_addr;
	msu_byte_t          wdata, next_wdata;
	logic [1:0]         pend, next_pend;
	msu_byte_t          rbyte, next_rbyte;
	logic [31:0]        next_prdata;
	logic               next_pready;
	logic               next_pslverr;
	logic               access;

	assign access = psel && penable && !pready;

	// One order at a time; after a read order the next transfer is held with pready low
	// until its byte is back, which keeps software from reordering the unit's sequence.
	always_comb begin
		next_wr      = 1'b0;
		next_rd      = 1'b0;
		next_addr    = addr;
		next_wdata   = wdata;
		next_pend    = {pend[0], 1'b0};
		next_rbyte   = pend[1] ? port.rdata : rbyte;
		next_prdata  = prdata;
		next_pready  = 1'b0;
		next_pslverr = 1'b0;
		if (access && pend == 2'b00 && !wr && !rd) begin
			next_pready = 1'b1;
			if (paddr == `MSU_HOST_CMD) begin
				next_prdata = 32'h0;
				if (pwrite) begin
					// Order of issue is the order software writes.
					next_addr  = pwdata[10:8];
					next_wdata = pwdata[7:0];
					next_rd    = pwdata[`MSU_CMD_RD];
					next_wr    = !pwdata[`MSU_CMD_RD];
					next_pend  = {1'b0, pwdata[`MSU_CMD_RD]};
				end
			end else if (paddr == `MSU_HOST_STAT) begin
				next_prdata = {24'h0, rbyte};
			end else begin
				next_prdata  = 32'h0;
				next_pslverr = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr      <= 1'b0;
			rd      <= 1'b0;
			addr    <= 3'h0;
			wdata   <= 8'h00;
			pend    <= 2'b00;
			rbyte   <= 8'h00;
			prdata  <= 32'h0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			wr      <= next_wr;
			rd      <= next_rd;
			addr    <= next_addr;
			wdata   <= next_wdata;
			pend    <= next_pend;
			rbyte   <= next_rbyte;
			prdata  <= next_prdata;
			pready  <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	assign port.wr    = wr;
	assign port.rd    = rd;
	assign port.addr  = addr;
	assign port.wdata = wdata;
endmodule

// ---- core/msu_if.sv ----
// Register port joining the processor side to the arithmetic unit.
interface msu_if;
	logic               wr;
	logic               rd;
	msu_pkg::msu_addr_t addr;
	msu_pkg::msu_byte_t wdata;
	msu_pkg::msu_byte_t rdata;

	modport dev (input wr, input rd, input addr, input wdata, output rdata);
	modport host (output wr, output rd, output addr, output wdata,
		input rdata);
endinterface

// ---- core/msu_map.svh ----
// Register indices, field positions and cycle counts of the arithmetic unit.
`ifndef MSU_MAP_SVH
`define MSU_MAP_SVH

// Unit register indices on the special function register port.
`define MSU_A_B0        3'h0
`define MSU_A_B1        3'h1
`define MSU_A_B2        3'h2
`define MSU_A_B3        3'h3
`define MSU_A_B4        3'h4
`define MSU_A_B5        3'h5
`define MSU_A_CTRL      3'h6

// Control register field positions and reset value.
`define MSU_CTRL_ERR    7
`define MSU_CTRL_OVF    6
`define MSU_CTRL_SLR    5
`define MSU_CTRL_RST    8'h00

// Execution times in machine cycles, then shift steps per cycle and the normalize step limit.
`define MSU_DIV32_MC    6
`define MSU_DIV16_MC    4
`define MSU_MUL_MC      4
`define MSU_SH_FIRST    4
`define MSU_SH_STEP     6
`define MSU_NORM_MAX    31

// Controller register byte offsets on APB, then the read bit of the command word.
`define MSU_HOST_CMD    12'h000
`define MSU_HOST_STAT   12'h004
`define MSU_CMD_RD      16

`endif

// ---- core/msu_pkg.sv ----
// Types shared by both ends of the arithmetic unit.
package msu_pkg;
	typedef enum logic [2:0] {
		MSU_IDLE  = 3'b000,
		MSU_LOAD  = 3'b001,
		MSU_CALC  = 3'b011,
		MSU_READ  = 3'b010,
		MSU_SHIFT = 3'b110
	} msu_state_t;

	typedef enum logic [1:0] {
		MSU_OP_DIV32 = 2'h0,
		MSU_OP_DIV16 = 2'h1,
		MSU_OP_MUL   = 2'h2,
		MSU_OP_SHIFT = 2'h3
	} msu_op_t;

	typedef logic [2:0] msu_addr_t;
	typedef logic [7:0] msu_byte_t;
endpackage

// ---- core/msu_shift_step.sv ----
// One machine cycle of shifting: up to a given number of single-bit steps.
module msu_shift_step #(
	parameter int MAXSTEP = 6
) (
	// Value and controls.
	input  wire logic [31:0] val_in,
	input  wire logic        right,
	input  wire logic        norm,
	input  wire logic [2:0]  limit,
	input  wire logic [4:0]  remaining,
	// Result.
	output logic      [31:0] val_out,
	output logic      [2:0]  used
);
	// Each step shifts in a zero; normalize stops once the top bit is one.
	always_comb begin
		val_out = val_in;
		used    = 3'h0;
		for (int i = 0; i < MAXSTEP; i++) begin
			if (3'(i) < limit && 5'(i) < remaining &&
			    !(norm && val_out[31])) begin
				val_out = right ? {1'b0, val_out[31:1]}
				                : {val_out[30:0], 1'b0};
				used    = 3'(used + 3'h1);
			end
		end
	end
endmodule

// ---- core/msu_unit.sv ----
// Multiply, divide, shift and normalize unit behind a byte register port.
//
// The address map and the APB register port were left to the implementer.
`include "msu_map.svh"

module msu_unit (
	// Clock and reset.
	input  wire logic pclk,
	input  wire logic presetn,
	// Register port from the processor.
	msu_if.dev        port
);
	import msu_pkg::*;

	//////////////////////////////////////////////////////////////////////
	// State.
	msu_state_t state, next_state;
	msu_op_t    op, next_op;
	msu_byte_t  md [6];
	msu_byte_t  next_md [6];
	logic       shift_right_sel, next_slr;
	logic [4:0] sc, next_sc;
	logic       ovf, next_ovf;
	logic       err, next_err;
	logic [2:0] cnt, next_cnt;
	logic [5:0] seen, next_seen;
	logic       sec4, next_sec4;
	logic       norm, next_norm;
	logic       first, next_first;
	logic [4:0] rem, next_rem;
	logic [4:0] done, next_done;
	msu_byte_t  rdata, next_rdata;

	//////////////////////////////////////////////////////////////////////
	// Arithmetic, computed from the operand bytes as they stand.
	logic [31:0] dividend32, quo32, product, sh_val, sh_out;
	logic [15:0] dividend16, divisor, mcand, rem32, quo16, rem16;
	logic [2:0]  sh_used;
	logic        set_err;

	// Plain unsigned operators; no sign is ever applied.
	assign dividend32 = {md[3], md[2], md[1], md[0]};
	assign dividend16 = {md[1], md[0]};
	assign mcand      = {md[1], md[0]};
	assign divisor    = {md[5], md[4]};
	assign quo32      = (divisor == 16'h0000) ? 32'h0 : dividend32 / divisor;
	assign rem32      = (divisor == 16'h0000) ? 16'h0
	                  : 16'(dividend32 % divisor);
	assign quo16      = (divisor == 16'h0000) ? 16'h0 : dividend16 / divisor;
	assign rem16      = (divisor == 16'h0000) ? 16'h0 : dividend16 % divisor;
	assign product    = mcand * divisor;
	assign sh_val     = dividend32;

	// First cycle does four steps, later cycles six, so 31 fit in six.
	msu_shift_step #(.MAXSTEP(`MSU_SH_STEP)) msu_shift_step_i (
		.val_in   (sh_val),
		.right    (shift_right_sel),
		.norm     (norm),
		.limit    (first ? 3'(`MSU_SH_FIRST) : 3'(`MSU_SH_STEP)),
		.remaining(rem),
		.val_out  (sh_out),
		.used     (sh_used)
	);

	//////////////////////////////////////////////////////////////////////
	// Sequence control, register writes and reads.
	always_comb begin
		next_state = state;
		next_op    = op;
		for (int i = 0; i < 6; i++) begin
			next_md[i] = md[i];
		end
		next_slr   = shift_right_sel;
		next_sc    = sc;
		next_ovf   = ovf;
		next_cnt   = cnt;
		next_seen  = seen;
		next_sec4  = sec4;
		next_norm  = norm;
		next_first = first;
		next_rem   = rem;
		next_done  = done;
		next_rdata = rdata;
		set_err    = 1'b0;

		// Background work: the timed calculation and the shifter.
		case (state)
			MSU_CALC: begin
				next_cnt = 3'(cnt - 3'h1);
				if (cnt == 3'h1) begin
					next_state = MSU_READ;
					case (op)
						MSU_OP_DIV32: begin
							{next_md[3], next_md[2], next_md[1], next_md[0]} = quo32;
							{next_md[5], next_md[4]} = rem32;
							next_ovf = (divisor == 16'h0000);
						end
						MSU_OP_DIV16: begin
							{next_md[1], next_md[0]} = quo16;
							{next_md[5], next_md[4]} = rem16;
							next_ovf = (divisor == 16'h0000);
						end
						default: begin
							{next_md[3], next_md[2], next_md[1], next_md[0]} = product;
							next_ovf = (product[31:16] != 16'h0000);
						end
					endcase
				end
			end
			MSU_SHIFT: begin
				{next_md[3], next_md[2], next_md[1], next_md[0]} = sh_out;
				next_first = 1'b0;
				next_rem   = 5'(rem - 5'(sh_used));
				next_done  = 5'(done + 5'(sh_used));
				if (5'(sh_used) == rem || (norm && sh_out[31])) begin
					next_state = MSU_READ;
					if (norm) begin
						next_sc = 5'(done + 5'(sh_used));
					end
				end
			end
			default: ;
		endcase

		// Processor writes take priority over background updates.
		if (port.wr) begin
			if (port.addr <= `MSU_A_B5) begin
				next_md[port.addr] = port.wdata;
			end
			if (state == MSU_SHIFT && port.addr <= `MSU_A_B3) begin
				set_err = 1'b1;
			end
			case (port.addr)
				`MSU_A_B0: begin
					// A rewrite during any phase is an interruption.
					set_err    = set_err | (state != MSU_IDLE);
					next_state = MSU_LOAD;
					next_seen  = 6'h01;
					next_sec4  = 1'b0;
				end
				`MSU_A_B5: begin
					if (state == MSU_LOAD) begin
						next_state = MSU_CALC;
						// Bytes 2 and 3 seen means long division.
						if (seen[2] && seen[3]) begin
							next_op  = MSU_OP_DIV32;
							next_cnt = 3'(`MSU_DIV32_MC);
						end else if (sec4) begin
							next_op  = MSU_OP_MUL;
							next_cnt = 3'(`MSU_MUL_MC);
						end else begin
							next_op  = MSU_OP_DIV16;
							next_cnt = 3'(`MSU_DIV16_MC);
						end
					end
				end
				`MSU_A_CTRL: begin
					// Writes leave the error flag alone and reload the overflow flag; the rest starts a shift.
					next_slr   = port.wdata[`MSU_CTRL_SLR];
					next_sc    = port.wdata[4:0];
					next_op    = MSU_OP_SHIFT;
					next_state = MSU_SHIFT;
					next_first = 1'b1;
					next_done  = 5'h00;
					next_norm  = (port.wdata[4:0] == 5'h00);
					next_rem   = (port.wdata[4:0] == 5'h00)
					           ? 5'(`MSU_NORM_MAX) : port.wdata[4:0];
					next_ovf   = (port.wdata[4:0] == 5'h00) && md[3][7];
				end
				default: begin
					if (state == MSU_LOAD && port.addr <= `MSU_A_B5) begin
						if (seen == 6'h01 && port.addr == `MSU_A_B4) begin
							next_sec4 = 1'b1;
						end
						next_seen[port.addr] = 1'b1;
					end
				end
			endcase
		end

		// Reads: the last result byte releases monitoring.
		if (port.rd) begin
			if (port.addr == `MSU_A_CTRL) begin
				next_rdata = {err, ovf, shift_right_sel, sc};
			end else if (port.addr <= `MSU_A_B5) begin
				next_rdata = md[port.addr];
			end else begin
				next_rdata = 8'h00;
			end
			if (state == MSU_SHIFT && port.addr <= `MSU_A_B3) begin
				set_err = 1'b1;
			end
			if (state == MSU_READ &&
			    ((port.addr == `MSU_A_B5 && op <= MSU_OP_DIV16) ||
			     (port.addr == `MSU_A_B3 && op >= MSU_OP_MUL))) begin
				next_state = MSU_IDLE;
			end
		end

		// Error flag: a new event wins over the clearing read.
		next_err = set_err |
		           (err & ~(port.rd && port.addr == `MSU_A_CTRL));
	end

	// Registers only.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= MSU_IDLE;
			op    <= MSU_OP_DIV32;
			for (int i = 0; i < 6; i++) begin
				md[i] <= 8'h00;
			end
			shift_right_sel   <= 1'b0;
			sc    <= 5'h00;
			ovf   <= 1'b0;
			err   <= 1'b0;
			cnt   <= 3'h0;
			seen  <= 6'h00;
			sec4  <= 1'b0;
			norm  <= 1'b0;
			first <= 1'b0;
			rem   <= 5'h00;
			done  <= 5'h00;
			rdata <= 8'h00;
		end else begin
			state <= next_state;
			op    <= next_op;
			for (int i = 0; i < 6; i++) begin
				md[i] <= next_md[i];
			end
			shift_right_sel   <= next_slr;
			sc    <= next_sc;
			ovf   <= next_ovf;
			err   <= next_err;
			cnt   <= next_cnt;
			seen  <= next_seen;
			sec4  <= next_sec4;
			norm  <= next_norm;
			first <= next_first;
			rem   <= next_rem;
			done  <= next_done;
			rdata <= next_rdata;
		end
	end

	assign port.rdata = rdata;
endmodule

// ---- verif/msu_chk.sv ----
// Checker watching the register port between the two ends of the unit.
`include "msu_map.svh"

module msu_chk (
	// Clock and reset.
	input wire logic               pclk,
	input wire logic               presetn,
	// Register port.
	input wire logic               wr,
	input wire logic               rd,
	input wire msu_pkg::msu_addr_t addr,
	input wire msu_pkg::msu_byte_t wdata,
	input wire msu_pkg::msu_byte_t rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	import msu_pkg::*;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic armed, err_exp, clean, plain;
	logic next_armed, next_err, next_clean, next_plain;

	////////////////////////////////////////////////////////////////////////
	// Track when the error flag must read set or clear. Conservative: any
	// doubtful case drops the expectation rather than risk a false alarm.
	always_comb begin
		next_armed = armed;
		next_err = err_exp;
		if (wr && addr == `MSU_A_B0) begin
			next_err = err_exp | armed;
			next_armed = 1'b1;
		end
		if (rd && (addr == `MSU_A_B3 || addr == `MSU_A_B5 ||
			addr == `MSU_A_CTRL))
			next_armed = 1'b0;
		if (rd && addr == `MSU_A_CTRL)
			next_err = 1'b0;
		next_clean = (rd && addr == `MSU_A_CTRL) ? 1'b1 :
			(wr || rd) ? 1'b0 : clean;
		next_plain = wr ? (addr == `MSU_A_CTRL && wdata[4:0] != 5'h00)
			: plain;
	end

	// Register the helper state.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			armed <= 1'b0;
			err_exp <= 1'b0;
			clean <= 1'b0;
			plain <= 1'b0;
		end else begin
			armed <= next_armed;
			err_exp <= next_err;
			clean <= next_clean;
			plain <= next_plain;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// A read of the control register.
	sequence ctrl_rd;
		rd && addr == `MSU_A_CTRL;
	endsequence

	wr_rd_excl_a: assert property (!(wr && rd))
		else $error("write and read strobes high together");
	wr_pulse_a: assert property (wr |=> !wr)
		else $error("write strobe longer than one cycle");
	rd_gap_a: assert property (rd |=> !rd && !wr)
		else $error("access follows a read too closely");
	rdata_hold_a: assert property (!rd |=> $stable(rdata))
		else $error("read data moved without a read");
	unmapped_rd_a: assert property (rd && addr == 3'h7 |=> !rdata)
		else $error("unmapped register read not zero");
	err_set_a: assert property (ctrl_rd ##0 err_exp |=> rdata[7])
		else $error("error flag missing after restart");
	err_clear_a: assert property (ctrl_rd ##0 clean |=> !rdata[7])
		else $error("error flag not cleared by read");
	ovf_shift_a: assert property (ctrl_rd ##0 plain |=> !rdata[6])
		else $error("overflow flag set after plain shift");
endmodule

// ---- verif/msu_unit_test.sv ----
// Testbench driving the controller over APB with the unit behind it.
`include "msu_map.svh"

module msu_unit_test;
	timeunit 1ns;
	timeprecision 1ps;
	import msu_pkg::*;

	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	int          errors, cmp_count;

	msu_if bus ();
	msu_unit msu_unit_i (.pclk(pclk), .presetn(presetn), .port(bus.dev));
	msu_host msu_host_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .port(bus.host));
	msu_chk msu_chk_i (.pclk(pclk), .presetn(presetn), .wr(bus.wr),
		.rd(bus.rd), .addr(bus.addr), .wdata(bus.wdata),
		.rdata(bus.rdata));

	////////////////////////////////////////////////////////////////////////
	// Clock at 25 MHz.
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// One APB transfer; holds everything until pready is sampled high.
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic uw(input msu_addr_t a, input msu_byte_t d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, `MSU_HOST_CMD, {16'h0000, 5'h00, a, d}, r, e);
	endtask

	// A unit read needs an order, then a status fetch.
	task automatic ur(input msu_addr_t a, output msu_byte_t d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, `MSU_HOST_CMD, {15'h0000, 1'b1, 5'h00, a, 8'h00}, r, e);
		apb(1'b0, `MSU_HOST_STAT, 32'h0000_0000, r, e);
		d = r[7:0];
	endtask

	task automatic rd32(output logic [31:0] v);
		msu_byte_t b;
		for (int i = 0; i < 4; i++) begin
			ur(msu_addr_t'(i), b);
			v[8*i +: 8] = b;
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// Scenarios.
	task automatic t_mul(input logic [15:0] a, input logic [15:0] b);
		logic [31:0] v, p;
		msu_byte_t   c;
		p = {16'h0000, a} * {16'h0000, b};
		uw(3'h0, a[7:0]);
		uw(3'h4, b[7:0]);
		uw(3'h1, a[15:8]);
		uw(3'h5, b[15:8]);
		repeat (`MSU_MUL_MC) @(posedge pclk);
		rd32(v);
		chk(v, p);
		ur(3'h6, c);
		chk({31'h0, c[6]}, {31'h0, p > 32'h0000_FFFF});
		chk({31'h0, c[7]}, 32'h0);
		$display("multiply test done");
	endtask

	task automatic t_div32(input logic [31:0] n, input logic [15:0] d);
		logic [47:0] op;
		logic [31:0] q;
		msu_byte_t   r0, r1, c;
		op = {d, n};
		for (int i = 0; i < 6; i++)
			uw(msu_addr_t'(i), op[8*i +: 8]);
		repeat (`MSU_DIV32_MC) @(posedge pclk);
		rd32(q);
		ur(3'h4, r0);
		ur(3'h5, r1);
		chk(q, n / d);
		chk({16'h0000, r1, r0}, n % d);
		ur(3'h6, c);
		chk({31'h0, c[6]}, 32'h0);
		$display("long divide test done");
	endtask

	task automatic t_div16(input logic [15:0] n, input logic [15:0] d);
		msu_byte_t q0, q1, r0, r1, c;
		uw(3'h0, n[7:0]);
		uw(3'h1, n[15:8]);
		uw(3'h4, d[7:0]);
		uw(3'h5, d[15:8]);
		repeat (`MSU_DIV16_MC) @(posedge pclk);
		ur(3'h0, q0);
		ur(3'h1, q1);
		ur(3'h4, r0);
		ur(3'h5, r1);
		chk({q1, q0}, (d == 0) ? 16'h0000 : n / d);
		chk({r1, r0}, (d == 0) ? 16'h0000 : n % d);
		ur(3'h6, c);
		chk({31'h0, c[6]}, {31'h0, d == 16'h0000});
		$display("short divide test done");
	endtask

	// Mask picks the control bits whose value is known afterwards.
	task automatic t_shift(input logic [31:0] v, input msu_byte_t c,
		input logic [31:0] ev, input msu_byte_t ec, input msu_byte_t m);
		logic [31:0] got;
		msu_byte_t   x;
		for (int i = 0; i < 4; i++)
			uw(msu_addr_t'(i), v[8*i +: 8]);
		uw(3'h6, c);
		repeat (`MSU_SH_STEP) @(posedge pclk);
		rd32(got);
		chk(got, ev);
		ur(3'h6, x);
		chk({24'h0, x & m}, {24'h0, ec});
		$display("shift test done");
	endtask

	task automatic t_err();
		msu_byte_t c;
		uw(3'h0, 8'h11);
		uw(3'h0, 8'h22);
		ur(3'h6, c);
		chk({31'h0, c[7]}, 32'h1);
		ur(3'h6, c);
		chk({31'h0, c[7]}, 32'h0);
		// A long shift is still running when byte0 is read back.
		uw(3'h6, 8'h1F);
		ur(3'h0, c);
		ur(3'h6, c);
		chk({31'h0, c[7]}, 32'h1);
		$display("error flag test done");
	endtask

	task automatic t_bad();
		logic [31:0] r;
		logic        e;
		msu_byte_t   c;
		apb(1'b1, 12'h008, 32'h0000_00A5, r, e);
		chk({31'h0, e}, 32'h1);
		apb(1'b0, 12'h008, 32'h0000_0000, r, e);
		chk({31'h0, e}, 32'h1);
		chk(r, 32'h0);
		ur(3'h7, c);
		chk({24'h0, c}, 32'h0);
		$display("unmapped access test done");
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence; reset held for two cycles.
	initial begin
		errors = 0;
		cmp_count = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_mul(16'hABCD, 16'h1234);
		t_mul(16'h00FF, 16'h0101);
		t_div32(32'h89AB_CDEF, 16'h0123);
		t_div16(16'hFFFF, 16'h0007);
		t_div16(16'h1234, 16'h0000);
		t_shift(32'h0F00_00F1, 8'h05, 32'h0F00_00F1 << 5, 8'h00, 8'hC0);
		t_shift(32'h8000_0001, 8'h3F, 32'h0000_0001, 8'h00, 8'hC0);
		t_shift(32'h0000_1000, 8'h00, 32'h8000_0000, 8'h13, 8'hFF);
		t_shift(32'h8000_0000, 8'h00, 32'h8000_0000, 8'h40, 8'hFF);
		t_err();
		t_bad();
		print_verdict();
	end

	// Watchdog: the run needs a few thousand cycles at most.
	initial begin
		repeat (20000) @(posedge pclk);
		errors++;
		print_verdict();
	end
endmodule
